//--- common/cm_defines.svh
/*
 Offsets, field positions, write masks and reset values of the
 common-mode and lead-mode configuration block.
 Assumes a 32-bit AHB-Lite slave; byte address is four times the index.
*/
`ifndef CM_DEFINES_SVH
`define CM_DEFINES_SVH

// ---------------------------------------------------------------
// Register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define CH_CTRL_IDX      8'h01
`define CM_REF_IDX       8'h05
`define FRM_CTRL_IDX     8'h0A
`define STATUS_IDX       8'h10

// ---------------------------------------------------------------
// channel_control_reg fields
// ---------------------------------------------------------------
`define CH_EN_LSB        0
`define CH_POWER_BIT     4
`define CH_BIAS_SEL_LSB  6
`define CH_BIAS_EN_BIT   8
`define CH_RESP_EN_BIT   9
`define CH_CONFIG_BIT    10
`define CH_WR_MASK       32'h000007DF

// ---------------------------------------------------------------
// cm_reference_control_reg fields
// ---------------------------------------------------------------
`define CM_RA_BIT        0
`define CM_LL_BIT        1
`define CM_LA_BIT        2
`define CM_V1_BIT        3
`define CM_CE_BIT        4
`define CM_EXT_BIT       5
`define CM_DRIVE_BIT     6
`define CM_CE_EN_BIT     8
`define CM_WR_MASK       32'h0000017F

// ---------------------------------------------------------------
// frame_control_reg fields
// ---------------------------------------------------------------
`define FRM_RATE_LSB     0
`define FRM_FORMAT_BIT   4
`define FRM_WR_MASK      32'h00000013
`define RATE_2K          2'h0
`define RATE_16K         2'h1

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CH_CTRL_RST      32'h00000000
`define CM_REF_RST       32'h00000000
`define FRM_CTRL_RST     32'h00000000

`endif

//--- common/cm_pkg.sv
/*
 Types shared by the configuration block and its two helpers.
 Assumes the offsets and fields come from cm_defines.svh.
*/
package cm_pkg;

   typedef enum logic [2:0]
   {
      MODE_ANALOG,
      MODE_DIGITAL,
      MODE_CE_A,
      MODE_ELECTRODE,
      MODE_CE_B,
      MODE_UNSUPPORTED
   } lead_mode_t;

   typedef struct packed
   {
      logic power;
      logic drive;
      logic ext;
      logic la;
      logic ll;
      logic ra;
      logic v1;
      logic ce;
   } cm_select_t;

   typedef struct packed
   {
      logic ext;
      logic ref_sw;
      logic la;
      logic ll;
      logic ra;
      logic v1;
      logic ce;
   } cm_switch_t;

   typedef struct packed
   {
      logic signed [23:0] w1;
      logic signed [23:0] w2;
      logic signed [23:0] w3;
   } sample_set_t;

   typedef struct packed
   {
      logic        valid;
      sample_set_t words;
   } former_state_t;

   typedef struct packed
   {
      logic [31:0] ch_ctrl;
      logic [31:0] cm_ctrl;
      logic [31:0] frm_ctrl;
      logic        wr_pend;
      logic [7:0]  wr_idx;
      logic [31:0] hrdata;
      logic        readyout;
      cm_switch_t  sw;
      logic [4:0]  bias_sum;
      logic [3:0]  bias_tap;
      logic [3:0]  chan_sw;
      logic [2:0]  resp;
      lead_mode_t  mode;
      logic        rate_bad;
   } top_state_t;

endpackage

//--- logic/cm_switch_decoder.sv
/*
 Combinational decoder from the common-mode selection bits to the
 analog switch controls. Assumes the caller registers its outputs.
*/
`timescale 1ns/1ns
module cm_switch_decoder
   import cm_pkg::*;
(
   input  cm_select_t sel,
   output cm_switch_t sw,
   output logic [4:0] bias_sum
);

   logic any_el;

   always_comb
   begin
      sw       = '0;
      bias_sum = '0;
      any_el   = sel.la | sel.ll | sel.ra | sel.v1 | sel.ce;
      if (!sel.power)
      begin
         sw = '0;                                  // see [RULE_01] see [RULE_19]
      end
      else if (sel.ext)
      begin
         sw.ext = 1'b1;                            // see [RULE_03] see [RULE_05]
      end
      else if (sel.drive || !any_el)
      begin
         // Drive mode steers the electrodes to the bias amplifier instead
         sw.ref_sw = 1'b1;                         // see [RULE_02] see [RULE_07]
         bias_sum  = {5{sel.drive}} & {sel.la, sel.ll, sel.ra, sel.v1, sel.ce};
      end
      else
      begin
         sw.la = sel.la;                           // see [RULE_04] see [RULE_06]
         sw.ll = sel.ll;
         sw.ra = sel.ra;
         sw.v1 = sel.v1;
         sw.ce = sel.ce;
      end
   end

endmodule

//--- logic/lead_word_former.sv
/*
 Forms the three output words of each sample set taken in a supported lead mode from the channel
 samples according to the lead mode. Samples come from same-clock logic.
*/
`timescale 1ns/1ns
module lead_word_former
   import cm_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  lead_mode_t       mode,
   input  wire logic        in_valid,
   input  sample_set_t      in_set,
   output logic             out_valid,
   output sample_set_t      out_set
);

   former_state_t st;
   former_state_t next_st;
   logic signed [25:0] third;

   function automatic logic signed [25:0] sub26(input logic signed [23:0] a,
                                                input logic signed [23:0] b);
      sub26 = 26'(a) - 26'(b);
   endfunction

   always_comb
   begin
      next_st       = st;
      next_st.valid = 1'b0;
      third         = (26'(in_set.w1) + 26'(in_set.w2)) / 26'sd3;
      if (in_valid && mode != MODE_UNSUPPORTED)
      begin
         next_st.valid = 1'b1;
         next_st.words = in_set;
         case (mode)
            MODE_ANALOG:
            begin
               // Lead two arrives inverted from the analog stage
               next_st.words.w2 = 24'(sub26(24'sd0, in_set.w2)); // see [RULE_18]
            end
            MODE_DIGITAL:
            begin
               next_st.words.w1 = 24'(sub26(in_set.w1, in_set.w3)); // see [RULE_17]
               next_st.words.w2 = 24'(sub26(in_set.w2, in_set.w3));
               next_st.words.w3 = 24'(sub26(in_set.w2, in_set.w1));
            end
            MODE_CE_A:
            begin
               next_st.words.w3 = 24'(26'(in_set.w3) - third);   // see [RULE_11]
            end
            default:
            begin
               next_st.words = in_set;                         // see [RULE_12] see [RULE_13]
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign out_valid = st.valid;
   assign out_set   = st.words;

endmodule

//--- logic/cm_config_top.sv
/*
 Common-mode switch and lead-mode configuration block with its
 AHB-Lite register slave. Assumes a single AHB-Lite master on clk_sys,
 channel samples on clk_sys, and analog switches driven from flops.
*/
//
// Overview of operation
// [RULE_01] Power enable low opens every common-mode switch regardless of other bits.
// [RULE_02] Powered, no external or electrode bits: only the reference switch closes.
// [RULE_03] Powered with external select set: only the external switch closes.
// [RULE_04] Powered, drive and external clear: each set electrode bit closes its switch.
// [RULE_05] Reference and external switches are never closed together.
// [RULE_06] Powered with external open, at least one electrode or reference switch closes.
// [RULE_07] Reference closes only when all five electrode switches are open.
// [RULE_08] Format bit 4 of frame control: 0 lead words, 1 electrode words.
// [RULE_09] Config bit 10 of channel control: 0 single-ended, 1 differential.
// [RULE_10] Bit 8 of common-mode control enables common-electrode referencing.
// [RULE_11] Common electrode A: two limb leads, third is V3' less limb third.
// [RULE_12] Electrode mode: LA, LL, RA relative to internal common mode.
// [RULE_13] Common electrode B: LA, LL, V1 relative to common electrode.
// [RULE_14] Channel enable switch sits after the bias drive tap point.
// [RULE_15] Common electrode path gets the same mux and switch control.
// [RULE_16] Respiration path reaches only the first three electrode channels.
// [RULE_17] Digital lead mode computes leads, only at 2 kHz and 16 kHz.
// [RULE_18] Analog lead mode inverts the second word back to true polarity.
// [RULE_19] Precedence: power-down, then external, then electrode selection.
//
`timescale 1ns/1ns
`include "cm_defines.svh"
module cm_config_top
   import cm_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        sample_valid,
   input  sample_set_t      sample_in,
   output logic             word_valid,
   output sample_set_t      word_out,
   output cm_switch_t       cm_switch,
   output logic [4:0]       bias_sum_switch,
   output logic [3:0]       bias_tap,
   output logic [3:0]       channel_switch,
   output logic [2:0]       resp_route,
   output lead_mode_t       lead_mode,
   output logic             rate_unsupported
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   top_state_t st;
   top_state_t next_st;
   cm_select_t sel;
   cm_switch_t dec_sw;
   logic [4:0] dec_bias;
   logic       take;
   logic [7:0] a_idx;
   logic [31:0] status_word;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic lead_mode_t mode_of(input logic fmt,
                                          input logic cfg,
                                          input logic ce_en,
                                          input logic [1:0] rate);
      lead_mode_t m;
      m = MODE_UNSUPPORTED;
      case ({fmt, cfg, ce_en})                     // see [RULE_08] see [RULE_09] see [RULE_10]
         3'b010:  m = MODE_ANALOG;
         3'b000:  m = (rate == `RATE_2K || rate == `RATE_16K)
                      ? MODE_DIGITAL : MODE_UNSUPPORTED;  // see [RULE_17]
         3'b001:  m = MODE_CE_A;
         3'b100:  m = MODE_ELECTRODE;
         3'b101:  m = MODE_CE_B;
         default: m = MODE_UNSUPPORTED;
      endcase
      return m;
   endfunction

   function automatic logic [31:0] reg_read(input logic [7:0] idx,
                                            input logic [31:0] ch,
                                            input logic [31:0] cm,
                                            input logic [31:0] frm,
                                            input logic [31:0] stat);
      logic [31:0] d;
      case (idx)
         `CH_CTRL_IDX:  d = ch;
         `CM_REF_IDX:   d = cm;
         `FRM_CTRL_IDX: d = frm;
         `STATUS_IDX:   d = stat;
         default:       d = 32'h00000000;
      endcase
      return d;
   endfunction

   // ---------------------------------------------------------------
   // Common-mode selection from the registers
   // ---------------------------------------------------------------
   always_comb
   begin
      sel.power = next_st.ch_ctrl[`CH_POWER_BIT];
      sel.drive = next_st.cm_ctrl[`CM_DRIVE_BIT];
      sel.ext   = next_st.cm_ctrl[`CM_EXT_BIT];
      sel.la    = next_st.cm_ctrl[`CM_LA_BIT];
      sel.ll    = next_st.cm_ctrl[`CM_LL_BIT];
      sel.ra    = next_st.cm_ctrl[`CM_RA_BIT];
      sel.v1    = next_st.cm_ctrl[`CM_V1_BIT];
      sel.ce    = next_st.cm_ctrl[`CM_CE_BIT];
   end

   cm_switch_decoder u_decoder
   (
      .sel      (sel),
      .sw       (dec_sw),
      .bias_sum (dec_bias)
   );

   // ---------------------------------------------------------------
   // Bus slave and register update
   // ---------------------------------------------------------------
   always_comb
   begin
      next_st          = st;
      next_st.readyout = 1'b1;
      take             = hsel & hready & htrans[1];
      a_idx            = haddr[9:2];
      status_word      = 32'h00000000;

      // Data phase of a write taken on the previous edge
      if (st.wr_pend)
      begin
         case (st.wr_idx)
            `CH_CTRL_IDX:  next_st.ch_ctrl  = hwdata & `CH_WR_MASK;
            `CM_REF_IDX:   next_st.cm_ctrl  = hwdata & `CM_WR_MASK;
            `FRM_CTRL_IDX: next_st.frm_ctrl = hwdata & `FRM_WR_MASK;
            default:       next_st.ch_ctrl  = st.ch_ctrl;
         endcase
      end

      next_st.wr_pend = take & hwrite;
      next_st.wr_idx  = a_idx;

      // Switches follow the registers on the same edge the write lands
      next_st.sw       = dec_sw;
      next_st.bias_sum = dec_bias;

      // Bias tap lies ahead of the channel switch, so a disabled
      // channel can still carry the redirected bias drive
      for (int i = 0; i < 4; i++)
      begin
         next_st.bias_tap[i] = next_st.ch_ctrl[`CH_BIAS_EN_BIT]
                              & (next_st.ch_ctrl[`CH_BIAS_SEL_LSB +: 2] == 2'(i)); // see [RULE_14]
         next_st.chan_sw[i]  = next_st.ch_ctrl[`CH_EN_LSB + i] & next_st.ch_ctrl[`CH_POWER_BIT]; // see [RULE_15]
      end

      // Common electrode is channel 3 and is kept off the respiration path
      next_st.resp = {3{next_st.ch_ctrl[`CH_RESP_EN_BIT]}}
                     & next_st.ch_ctrl[`CH_EN_LSB +: 3]; // see [RULE_16]

      next_st.mode = mode_of(next_st.frm_ctrl[`FRM_FORMAT_BIT],
                             next_st.ch_ctrl[`CH_CONFIG_BIT],
                             next_st.cm_ctrl[`CM_CE_EN_BIT],
                             next_st.frm_ctrl[`FRM_RATE_LSB +: 2]);
      next_st.rate_bad = ~next_st.frm_ctrl[`FRM_FORMAT_BIT]
                         & ~next_st.ch_ctrl[`CH_CONFIG_BIT]
                         & ~next_st.cm_ctrl[`CM_CE_EN_BIT]
                         & (next_st.mode == MODE_UNSUPPORTED); // see [RULE_17]

      status_word[6:0]  = st.sw;
      status_word[10:8] = st.mode;
      status_word[12]   = st.rate_bad;
      status_word[19:16] = st.chan_sw;
      status_word[23:20] = st.bias_tap;

      // Read data is ready for the data phase; a write in its data
      // phase right now is already folded into a control register value returned, but not into status
      if (take && !hwrite)
      begin
         next_st.hrdata = reg_read(a_idx, next_st.ch_ctrl, next_st.cm_ctrl,
                                   next_st.frm_ctrl, status_word);
      end
      else
      begin
         next_st.hrdata = 32'h00000000;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st          <= '0;
         st.ch_ctrl  <= `CH_CTRL_RST;
         st.cm_ctrl  <= `CM_REF_RST;
         st.frm_ctrl <= `FRM_CTRL_RST;
         st.mode     <= MODE_DIGITAL;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Output word formation
   // ---------------------------------------------------------------
   lead_word_former u_former
   (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .mode      (st.mode),
      .in_valid  (sample_valid),
      .in_set    (sample_in),
      .out_valid (word_valid),
      .out_set   (word_out)
   );

   // ---------------------------------------------------------------
   // Outputs, all from flops except hresp, tied low
   // ---------------------------------------------------------------
   assign hrdata           = st.hrdata;
   assign hreadyout        = st.readyout;
   assign hresp            = 1'b0;
   assign cm_switch        = st.sw;
   assign bias_sum_switch  = st.bias_sum;
   assign bias_tap         = st.bias_tap;
   assign channel_switch   = st.chan_sw;
   assign resp_route       = st.resp;
   assign lead_mode        = st.mode;
   assign rate_unsupported = st.rate_bad;

endmodule

//--- tb/cm_config_sva.sv
/*
 Assertion checker for cm_config_top: switch legality and word forming.
 Assumes it is bound to cm_config_top and sees only its ports.
*/
`timescale 1ns/1ns
module cm_config_sva
   import cm_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       sample_valid,
   input sample_set_t     sample_in,
   input wire logic       word_valid,
   input sample_set_t     word_out,
   input cm_switch_t      cm_switch,
   input wire logic [3:0] bias_tap,
   input lead_mode_t      lead_mode,
   input wire logic       rate_unsupported
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // Switch legality
   // ---------------------------------------------------------------
   a_ref_ext_excl: assert property (!(cm_switch.ext && cm_switch.ref_sw))
      else $error("reference and external switches closed together");
   a_ext_alone: assert property (cm_switch.ext |-> cm_switch[5:0] == 6'h00)
      else $error("external switch closed with another switch");
   a_ref_alone: assert property (cm_switch.ref_sw |-> cm_switch[4:0] == 5'h00)
      else $error("reference switch closed with an electrode switch");
   a_tap_onehot: assert property ($onehot0(bias_tap))
      else $error("bias drive redirected into more than one path");

   // ---------------------------------------------------------------
   // Word forming, one cycle after each sample set
   // ---------------------------------------------------------------
   a_word_follows: assert property (sample_valid && lead_mode != MODE_UNSUPPORTED |=> word_valid)
      else $error("no word one cycle after a sample");
   a_unsup_silent: assert property (!sample_valid || lead_mode == MODE_UNSUPPORTED |=> !word_valid)
      else $error("word without a sample in a supported mode");
   a_analog_invert: assert property (sample_valid && lead_mode == MODE_ANALOG |=>
      word_out.w2 == -$past(sample_in.w2) && word_out.w1 == $past(sample_in.w1))
      else $error("analog mode second word not inverted");
   a_digital_lead: assert property (sample_valid && lead_mode == MODE_DIGITAL |=>
      word_out.w1 == $past(sample_in.w1) - $past(sample_in.w3))
      else $error("digital mode first lead wrong");
   a_electrode_pass: assert property (sample_valid && lead_mode inside {MODE_ELECTRODE, MODE_CE_B} |=>
      word_out == $past(sample_in))
      else $error("electrode words not passed through");
   a_rate_flag: assert property (rate_unsupported |-> lead_mode == MODE_UNSUPPORTED)
      else $error("rate flag without unsupported mode");

   c_ext: cover property (cm_switch.ext);
   c_limb_avg: cover property (cm_switch == 7'h1C);
   c_ce_a: cover property (sample_valid && lead_mode == MODE_CE_A);
   c_rate_bad: cover property (rate_unsupported);
endmodule

bind cm_config_top cm_config_sva cm_config_sva_inst
(
   .clk_sys          (clk_sys),
   .rst              (rst),
   .sample_valid     (sample_valid),
   .sample_in        (sample_in),
   .word_valid       (word_valid),
   .word_out         (word_out),
   .cm_switch        (cm_switch),
   .bias_tap         (bias_tap),
   .lead_mode        (lead_mode),
   .rate_unsupported (rate_unsupported)
);

//--- tb/test_common_mode_switch_and_lead_mode_select.sv
/*
 Self-checking bench for cm_config_top: table of configurations, then
 reset, masking, unmapped, back-to-back cases. Assumes one AHB master.
*/
`timescale 1ns/1ns
module test_common_mode_switch_and_lead_mode_select
   import cm_pkg::*;
;
   typedef struct packed
   {
      logic [11:0] ch;
      logic [11:0] cm;
      logic [4:0]  frm;
      logic [6:0]  sw;
      logic [3:0]  chs;
      logic [3:0]  tap;
      lead_mode_t  md;
      logic        rb;
   } row_t;

   logic clk_sys, rst, hsel, hwrite, sample_valid, hreadyout, hresp, word_valid, rate_unsupported;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize, resp_route;
   logic [4:0]  bias_sum_switch;
   logic [3:0]  bias_tap, channel_switch;
   wire logic   hready;
   sample_set_t sample_in, word_out;
   cm_switch_t  cm_switch;
   lead_mode_t  lead_mode;
   int          error_cnt = 0;
   int          cmp_count = 0;
   sample_set_t smp = '{24'h00012C, 24'h000064, 24'h00001E};
   sample_set_t smp2 = '{24'hFFFF00, 24'h000200, 24'h7FFFFF};
   logic [31:0] radr [3] = '{32'h00000004, 32'h00000014, 32'h00000028};
   logic [31:0] rmsk [3] = '{32'h000007DF, 32'h0000017F, 32'h00000013};
   row_t rows [13] = '{
      '{12'h00F, 12'h07F, 5'h00, 7'h00, 4'h0, 4'h0, MODE_DIGITAL, 1'b0},
      '{12'h010, 12'h000, 5'h00, 7'h20, 4'h0, 4'h0, MODE_DIGITAL, 1'b0},
      '{12'h010, 12'h067, 5'h01, 7'h40, 4'h0, 4'h0, MODE_DIGITAL, 1'b0},
      '{12'h01F, 12'h004, 5'h10, 7'h10, 4'hF, 4'h0, MODE_ELECTRODE, 1'b0},
      '{12'h1D0, 12'h007, 5'h10, 7'h1C, 4'h0, 4'h8, MODE_ELECTRODE, 1'b0},
      '{12'h410, 12'h01F, 5'h00, 7'h1F, 4'h0, 4'h0, MODE_ANALOG, 1'b0},
      '{12'h010, 12'h147, 5'h00, 7'h20, 4'h0, 4'h0, MODE_CE_A, 1'b0},
      '{12'h010, 12'h103, 5'h10, 7'h0C, 4'h0, 4'h0, MODE_CE_B, 1'b0},
      '{12'h410, 12'h100, 5'h00, 7'h20, 4'h0, 4'h0, MODE_UNSUPPORTED, 1'b0},
      '{12'h410, 12'h000, 5'h10, 7'h20, 4'h0, 4'h0, MODE_UNSUPPORTED, 1'b0},
      '{12'h410, 12'h100, 5'h10, 7'h20, 4'h0, 4'h0, MODE_UNSUPPORTED, 1'b0},
      '{12'h010, 12'h000, 5'h02, 7'h20, 4'h0, 4'h0, MODE_UNSUPPORTED, 1'b1},
      '{12'h010, 12'h000, 5'h13, 7'h20, 4'h0, 4'h0, MODE_ELECTRODE, 1'b0}};

   // One slave only, so its ready is the bus ready
   assign hready = hreadyout;

   cm_config_top cm_config_top_inst
   (
      .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid), .sample_in(sample_in),
      .word_valid(word_valid), .word_out(word_out), .cm_switch(cm_switch),
      .bias_sum_switch(bias_sum_switch), .bias_tap(bias_tap), .channel_switch(channel_switch),
      .resp_route(resp_route), .lead_mode(lead_mode), .rate_unsupported(rate_unsupported)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic sample_set_t expw(input lead_mode_t m, input sample_set_t s);
      sample_set_t e;
      e = s;
      case (m)
         MODE_ANALOG: e.w2 = -s.w2;
         MODE_DIGITAL:
         begin
            e.w1 = s.w1 - s.w3;
            e.w2 = s.w2 - s.w3;
            e.w3 = s.w2 - s.w1;
         end
         MODE_CE_A: e.w3 = s.w3 - (s.w1 + s.w2) / 3;
         default: e = s;
      endcase
      return e;
   endfunction

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Called just after a rising edge; holds each phase until ready is sampled high
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1)
         @(posedge clk_sys);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1)
         @(posedge clk_sys);
      r = hrdata;
   endtask

   task automatic setcfg(input logic [31:0] ch, input logic [31:0] cm, input logic [31:0] frm);
      bus(1'b1, 32'h00000004, ch, q);
      bus(1'b1, 32'h00000014, cm, q);
      bus(1'b1, 32'h00000028, frm, q);
      repeat (2) @(posedge clk_sys);
   endtask

   task automatic cw(input sample_set_t e);
      chk("word_w1", e.w1, word_out.w1);
      chk("word_w2", e.w2, word_out.w2);
      chk("word_w3", e.w3, word_out.w3);
   endtask

   task automatic send(input sample_set_t s, input lead_mode_t m);
      sample_valid <= 1'b1;
      sample_in <= s;
      @(posedge clk_sys);
      sample_valid <= 1'b0;
      @(posedge clk_sys);
      chk("word_valid", m != MODE_UNSUPPORTED, word_valid);
      if (m != MODE_UNSUPPORTED)
         cw(expw(m, s));
   endtask

   // ---------------------------------------------------------------
   // Clock, watchdog and tests
   // ---------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // The whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      finish_test();
   end

   initial
   begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      sample_valid = 1'b0;
      sample_in = '0;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 13; i++)
      begin
         setcfg({20'h00000, rows[i].ch}, {20'h00000, rows[i].cm}, {27'h0000000, rows[i].frm});
         chk("cm_switch", rows[i].sw, cm_switch);
         chk("channel_switch", rows[i].chs, channel_switch);
         chk("bias_tap", rows[i].tap, bias_tap);
         chk("lead_mode", rows[i].md, lead_mode);
         chk("rate_unsupported", rows[i].rb, rate_unsupported);
         bus(1'b0, 32'h00000040, 32'h00000000, q);
         chk("status", {rows[i].md, 1'b0, rows[i].sw}, q[10:0]);
         send(smp, rows[i].md);
         $display("Row %0d done", i);
      end
      rst <= 1'b1;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk("cm_switch", 7'h00, cm_switch);
      for (int j = 0; j < 3; j++)
      begin
         bus(1'b0, radr[j], 32'h00000000, q);
         chk("reset_value", 32'h00000000, q);
         bus(1'b1, radr[j], 32'hFFFFFFFF, q);
         bus(1'b0, radr[j], 32'h00000000, q);
         chk("masked_value", rmsk[j], q);
      end
      repeat (2) @(posedge clk_sys);
      chk("cm_switch", 7'h40, cm_switch);
      chk("lead_mode", MODE_UNSUPPORTED, lead_mode);
      $display("Test reset_and_mask done");
      bus(1'b1, 32'h0000003C, 32'hFFFFFFFF, q);
      bus(1'b0, 32'h0000003C, 32'h00000000, q);
      chk("unmapped", 32'h00000000, q);
      bus(1'b1, 32'h00000014, 32'h00000007, q);
      bus(1'b0, 32'h00000014, 32'h00000000, q);
      chk("read_after_write", 32'h00000007, q);
      chk("hresp", 1'b0, hresp);
      $display("Test bus_edges done");
      // Drive mode with the common electrode enabled: respiration must skip channel 3
      setcfg(32'h0000021D, 32'h00000047, 32'h00000000);
      chk("resp_route", 3'h5, resp_route);
      chk("bias_sum_switch", 5'h1C, bias_sum_switch);
      chk("channel_switch", 4'hD, channel_switch);
      chk("cm_switch", 7'h20, cm_switch);
      $display("Test bias_and_resp done");
      setcfg(32'h00000010, 32'h00000000, 32'h00000000);
      chk("cm_switch", 7'h20, cm_switch);
      sample_valid <= 1'b1;
      sample_in <= smp;
      @(posedge clk_sys);
      sample_in <= smp2;
      @(posedge clk_sys);
      sample_valid <= 1'b0;
      chk("word_valid", 1'b1, word_valid);
      cw(expw(MODE_DIGITAL, smp));
      @(posedge clk_sys);
      chk("word_valid", 1'b1, word_valid);
      cw(expw(MODE_DIGITAL, smp2));
      @(posedge clk_sys);
      chk("word_valid", 1'b0, word_valid);
      $display("Test back_to_back done");
      finish_test();
   end
endmodule
